//--- fci_pkg.sv
// constants, register map and state types of the flash command host
package fci_pkg;
  // clock rate and pin timing
  localparam int CLK_MHZ = 100;
  localparam int WE_LOW_NS = 40;
  localparam int READ_ACC_NS = 150;
  localparam int PD_RECOVER_NS = 480;
  localparam int WE_LOW_CYC = (WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_ACC_CYC = (READ_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int PD_RECOVER_CYC = (PD_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 6;

  // host register offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0C;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // control fields
  localparam int CTRL_GO_BIT = 4;
  localparam int CTRL_PD_BIT = 8;
  localparam int CTRL_VPP_BIT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_REFUSED_BIT = 1;
  localparam int ST_SUPLOW_BIT = 2;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_BYTE_LSB = 8;

  // device operation_status bit positions
  localparam int ENGINE_READY_BIT = 7;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int PROGRAM_FAIL_BIT = 4;
  localparam int SUPPLY_LOW_BIT = 3;

  // operations software may start
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_ARRAY = 4'h1;
  localparam logic [3:0] OP_STATUS = 4'h2;
  localparam logic [3:0] OP_SIG = 4'h3;
  localparam logic [3:0] OP_CLEAR = 4'h4;
  localparam logic [3:0] OP_PROGRAM = 4'h5;
  localparam logic [3:0] OP_ERASE = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME = 4'h8;
  localparam logic [3:0] OP_SIG_HV = 4'h9;

  // device command codes
  localparam logic [7:0] CMD_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;

  // read mode the device is believed to be in
  localparam logic [1:0] MODE_ARRAY = 2'h0;
  localparam logic [1:0] MODE_STATUS = 2'h1;
  localparam logic [1:0] MODE_SIG = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CYC_IDLE = 3'b001,
    CYC_ACT = 3'b010,
    CYC_END = 3'b100
  } fci_cyc_state_t;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_PDREC = 4'b0010,
    M_WAIT1 = 4'b0100,
    M_WAIT2 = 4'b1000
  } fci_main_state_t;
endpackage

//--- fci_bus_cycle.sv
// one read or write cycle on the flash pins
`timescale 1ns/1ps
module fci_bus_cycle (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // cycle request
  input wire logic start,
  input wire logic is_write,
  input wire logic hv,
  input wire logic [16:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  // flash pins
  output logic [16:0] flash_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_i,
  output logic id_voltage_en
);
  fci_pkg::fci_cyc_state_t state_q;
  logic [fci_pkg::CNT_W-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fci_pkg::CYC_IDLE;
      cnt_q <= '0;
      flash_addr <= 17'h0_0000;
      chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_strobe_n <= 1'b1;
      flash_dq_o <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      id_voltage_en <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state_q)
        fci_pkg::CYC_IDLE: begin
          if (start) begin
            flash_addr <= addr;
            flash_dq_o <= wdata;
            id_voltage_en <= hv;
            chip_select_n <= 1'b0;
            write_strobe_n <= !is_write;
            flash_dq_oe_n <= !is_write;
            output_enable_n <= is_write;
            cnt_q <= is_write ? fci_pkg::CNT_W'(fci_pkg::WE_LOW_CYC - 1)
                              : fci_pkg::CNT_W'(fci_pkg::READ_ACC_CYC - 1);
            state_q <= fci_pkg::CYC_ACT;
          end
        end
        fci_pkg::CYC_ACT: begin
          if (cnt_q == '0) begin
            // rising strobe latches address and data
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            if (!output_enable_n) begin
              rdata <= flash_dq_i;
            end
            state_q <= fci_pkg::CYC_END;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        fci_pkg::CYC_END: begin
          // strobes return high before any further read
          chip_select_n <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          id_voltage_en <= 1'b0;
          done <= 1'b1;
          state_q <= fci_pkg::CYC_IDLE;
        end
        default: state_q <= fci_pkg::CYC_IDLE;
      endcase
    end
  end

  // address and data stay put across the strobe
  sequence we_fall_s;
    $fell(write_strobe_n);
  endsequence
  sequence we_low_hold_s;
    !write_strobe_n && !chip_select_n && !flash_dq_oe_n;
  endsequence
  we_width_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    we_fall_s |-> we_low_hold_s [*4] ##1 write_strobe_n && !flash_dq_oe_n
                  && $stable(flash_addr) && $stable(flash_dq_o))
    else $error("write strobe pulse wrong");
  cmd_write_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !write_strobe_n |-> output_enable_n && !chip_select_n)
    else $error("write cycle with output enable low");
  strobe_gap_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(output_enable_n) |=> chip_select_n ##1 !$fell(output_enable_n))
    else $error("no strobe gap between reads");
  read_access_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(output_enable_n) |-> !output_enable_n [*8] ##8 $rose(output_enable_n))
    else $error("read access length wrong");
endmodule

//--- fci_host.sv
// flash command host: axi4-lite registers and command sequencing
// Behaviour
// - commands go as one or two writes
// - status latched late; strobe high between reads
// - clear status after supply low first
// - high voltage address bit reads identity
// - erase is 20H then D0H in block
// - clear status when erase failed; the host does not check the erase-fail bit
// - program is 40H then address/data
// - B0H suspends erase, D0H resumes
`timescale 1ns/1ps
module fci_host (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // flash pins
  output logic [16:0] flash_addr,
  output logic chip_select_n,
  output logic output_enable_n,
  output logic write_strobe_n,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_i,
  output logic powerdown_n,
  output logic program_supply_high_level,
  output logic id_voltage_en
);
  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // {is_write, byte} of the first cycle of an operation
  function automatic logic [8:0] first_word(input logic [3:0] op);
    case (op)
      fci_pkg::OP_ARRAY: first_word = {1'b1, fci_pkg::CMD_ARRAY};
      fci_pkg::OP_STATUS: first_word = {1'b1, fci_pkg::CMD_STATUS};
      fci_pkg::OP_SIG: first_word = {1'b1, fci_pkg::CMD_SIG};
      fci_pkg::OP_CLEAR: first_word = {1'b1, fci_pkg::CMD_CLEAR};
      fci_pkg::OP_PROGRAM: first_word = {1'b1, fci_pkg::CMD_PROG_SETUP};
      fci_pkg::OP_ERASE: first_word = {1'b1, fci_pkg::CMD_ERASE_SETUP};
      fci_pkg::OP_SUSPEND: first_word = {1'b1, fci_pkg::CMD_SUSPEND};
      fci_pkg::OP_RESUME: first_word = {1'b1, fci_pkg::CMD_CONFIRM};
      default: first_word = {1'b0, 8'h00};
    endcase
  endfunction

  function automatic logic is_alter(input logic [3:0] op);
    return op == fci_pkg::OP_PROGRAM || op == fci_pkg::OP_ERASE;
  endfunction

  logic [31:0] ctrl_q;
  logic [16:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] stat_byte_q;
  logic [1:0] mode_q;
  logic refused_q, suplow_q;
  logic aw_got_q, w_got_q;
  logic [4:0] awaddr_q;
  logic [31:0] wbus_q;
  logic [3:0] wstrb_q;
  logic go, wr_fire;
  fci_pkg::fci_main_state_t state_q;
  logic [3:0] op_q;
  logic stage_q, start_q;
  logic [fci_pkg::CNT_W-1:0] rec_q;
  logic cyc_done, cyc_write, cyc_hv;
  logic [7:0] cyc_wdata, cyc_rdata;
  logic [16:0] cyc_addr;
  logic busy;
  logic [8:0] fw;
  logic [31:0] addr_m, wdata_m;

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 5'h00;
      wbus_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fci_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wbus_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == fci_pkg::REG_CTRL
                        || awaddr_q == fci_pkg::REG_ADDR
                        || awaddr_q == fci_pkg::REG_WDATA)
                       ? fci_pkg::RESP_OKAY : fci_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign go = wr_fire && awaddr_q == fci_pkg::REG_CTRL && wstrb_q[0]
              && wbus_q[fci_pkg::CTRL_GO_BIT];
  assign addr_m = merge({15'h0000, addr_q}, wbus_q, wstrb_q);
  assign wdata_m = merge({24'h00_0000, wdata_q}, wbus_q, wstrb_q);

  // software registers; go bit is a strobe and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= fci_pkg::CTRL_RESET;
      addr_q <= 17'h0_0000;
      wdata_q <= 8'h00;
    end else if (wr_fire) begin
      case (awaddr_q)
        fci_pkg::REG_CTRL: begin
          ctrl_q <= merge(ctrl_q, wbus_q, wstrb_q) & 32'h0000_030F;
        end
        fci_pkg::REG_ADDR: addr_q <= addr_m[16:0];
        fci_pkg::REG_WDATA: wdata_q <= wdata_m[7:0];
        default: ;
      endcase
    end
  end

  // read channel answers one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fci_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fci_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fci_pkg::REG_CTRL: s_axi_rdata <= ctrl_q;
        fci_pkg::REG_ADDR: s_axi_rdata <= {15'h0000, addr_q};
        fci_pkg::REG_WDATA: s_axi_rdata <= {24'h00_0000, wdata_q};
        fci_pkg::REG_RDATA: s_axi_rdata <= {24'h00_0000, rdata_q};
        fci_pkg::REG_STATUS: s_axi_rdata <= {16'h0000, stat_byte_q,
                                             2'b00, mode_q, 1'b0, suplow_q,
                                             refused_q, busy};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= fci_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign busy = state_q != fci_pkg::M_IDLE;
  assign program_supply_high_level = ctrl_q[fci_pkg::CTRL_VPP_BIT];

  // cycle request follows the operation and its stage
  always_comb begin
    fw = first_word(op_q);
    cyc_write = stage_q ? 1'b1 : fw[8];
    cyc_wdata = stage_q ? (op_q == fci_pkg::OP_PROGRAM ? wdata_q
                                                       : fci_pkg::CMD_CONFIRM)
                        : fw[7:0];
    if (op_q == fci_pkg::OP_STATUS && stage_q) cyc_write = 1'b0;
    // other address lines low, bit 0 picks the code
    cyc_hv = op_q == fci_pkg::OP_SIG_HV;
    cyc_addr = cyc_hv ? {16'h0000, addr_q[0]} : addr_q;
  end

  // operation sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fci_pkg::M_IDLE;
      op_q <= fci_pkg::OP_READ;
      stage_q <= 1'b0;
      start_q <= 1'b0;
      rec_q <= '0;
      powerdown_n <= 1'b1;
      refused_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        fci_pkg::M_IDLE: begin
          if (powerdown_n == ctrl_q[fci_pkg::CTRL_PD_BIT]) begin
            powerdown_n <= !ctrl_q[fci_pkg::CTRL_PD_BIT];
            // wait out recovery before the first write strobe
            if (ctrl_q[fci_pkg::CTRL_PD_BIT] == 1'b0) begin
              rec_q <= fci_pkg::CNT_W'(fci_pkg::PD_RECOVER_CYC - 1);
              state_q <= fci_pkg::M_PDREC;
            end
          end else if (go) begin
            // no program or erase while supply low is recorded
            // program and erase need the high program supply
            if (!powerdown_n || (is_alter(wbus_q[3:0])
                && (suplow_q || !ctrl_q[fci_pkg::CTRL_VPP_BIT]))) begin
              refused_q <= 1'b1;
            end else begin
              refused_q <= 1'b0;
              op_q <= wbus_q[3:0];
              stage_q <= 1'b0;
              start_q <= 1'b1;
              state_q <= fci_pkg::M_WAIT1;
            end
          end
        end
        fci_pkg::M_PDREC: begin
          if (rec_q == '0) state_q <= fci_pkg::M_IDLE;
          else rec_q <= rec_q - 1'b1;
        end
        fci_pkg::M_WAIT1: begin
          if (cyc_done) begin
            // two-write sequences; status read after 70H
            if (is_alter(op_q) || op_q == fci_pkg::OP_STATUS) begin
              stage_q <= 1'b1;
              start_q <= 1'b1;
              state_q <= fci_pkg::M_WAIT2;
            end else begin
              state_q <= fci_pkg::M_IDLE;
            end
          end
        end
        fci_pkg::M_WAIT2: begin
          if (cyc_done) state_q <= fci_pkg::M_IDLE;
        end
        default: state_q <= fci_pkg::M_IDLE;
      endcase
    end
  end

  // believed read mode and recorded status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= fci_pkg::MODE_ARRAY;
      suplow_q <= 1'b0;
      stat_byte_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      if (!powerdown_n) mode_q <= fci_pkg::MODE_ARRAY;
      if (cyc_done && !cyc_write) begin
        rdata_q <= cyc_rdata;
        if (mode_q == fci_pkg::MODE_STATUS) begin
          stat_byte_q <= cyc_rdata;
          // failure and supply-low bits kept for software
          if (cyc_rdata[fci_pkg::SUPPLY_LOW_BIT]) suplow_q <= 1'b1;
        end
      end
      if (cyc_done && state_q == fci_pkg::M_WAIT1) begin
        case (op_q)
          fci_pkg::OP_ARRAY: mode_q <= fci_pkg::MODE_ARRAY;
          fci_pkg::OP_SIG: mode_q <= fci_pkg::MODE_SIG;
          fci_pkg::OP_CLEAR: suplow_q <= 1'b0;
          fci_pkg::OP_STATUS, fci_pkg::OP_PROGRAM, fci_pkg::OP_ERASE,
          fci_pkg::OP_SUSPEND, fci_pkg::OP_RESUME:
            mode_q <= fci_pkg::MODE_STATUS;
          default: ;
        endcase
      end
    end
  end

  fci_bus_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .is_write(cyc_write),
    .hv(cyc_hv),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .flash_addr(flash_addr),
    .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n),
    .write_strobe_n(write_strobe_n),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_i(flash_dq_i),
    .id_voltage_en(id_voltage_en)
  );

  // helper: cycles since powerdown released
  logic [fci_pkg::CNT_W-1:0] since_pd_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || !powerdown_n) since_pd_q <= '0;
    else if (since_pd_q != '1) since_pd_q <= since_pd_q + 1'b1;
  end

  pd_recover_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(write_strobe_n)
    |-> since_pd_q >= fci_pkg::CNT_W'(fci_pkg::PD_RECOVER_CYC))
    else $error("write strobe too soon after powerdown");
  pd_quiet_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !powerdown_n |-> chip_select_n && flash_dq_oe_n && write_strobe_n)
    else $error("pins active during powerdown");
  supply_clear_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    start_q && !stage_q && is_alter(op_q) |-> !suplow_q)
    else $error("program or erase with supply low recorded");
  hv_addr_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    id_voltage_en |-> flash_addr[16:1] == 16'h0000 && write_strobe_n)
    else $error("identity read address not clean");
  sequence erase_setup_s;
    $fell(write_strobe_n) && flash_dq_o == fci_pkg::CMD_ERASE_SETUP
    && op_q == fci_pkg::OP_ERASE;
  endsequence
  // confirm strobe falls seven cycles after the setup strobe
  sequence erase_confirm_s;
    $fell(write_strobe_n) && flash_dq_o == fci_pkg::CMD_CONFIRM
    && flash_addr == $past(flash_addr, 7);
  endsequence
  erase_pair_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    erase_setup_s |-> ##7 erase_confirm_s)
    else $error("erase confirm missing or in other block");
  erase_supply_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    erase_setup_s |-> program_supply_high_level)
    else $error("erase started without program supply");
endmodule

//--- fci_flash_model.sv
// behavioural flash device facing the host's pins
`timescale 1ns/1ps
module fci_flash_model #(
  // identity values are arbitrary
  parameter logic [7:0] MFG_ID = 8'hA7,
  parameter logic [7:0] DEV_ID = 8'h3C
) (
  // flash pins
  input wire logic [16:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic pd_n,
  input wire logic vpp,
  input wire logic hv,
  input wire logic [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [256];
  logic [7:0] sr_lat, rd_v, last;
  logic [1:0] mode, pend;
  logic ef, pf, vl, drv;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    {mode, pend, ef, pf, vl, sr_lat, last} = '0;
  end
  always @(negedge pd_n) {mode, pend} = '0;
  // later strobe latches; one merged strobe avoids a same-step race
  wire rd_strobe_n = oe_n | ce_n;
  always @(negedge rd_strobe_n) sr_lat = {2'h2, ef, pf, vl, 3'h0};
  always @(posedge we_n) if (!ce_n && pd_n) begin
    if (pend == 2'h1) begin
      if (vpp) mem[addr[7:0]] = din;
      else {pf, vl} = 2'h3;
      mode = 2'h1;
    end else if (pend == 2'h2) begin
      if (din != 8'hD0) {ef, pf} = 2'h3;
      else if (vpp) for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
      else {ef, vl} = 2'h3;
      mode = 2'h1;
    end else case (din)
      8'hFF: mode = 2'h0;
      8'h70, 8'hB0, 8'hD0: mode = 2'h1;
      8'h50: {ef, pf, vl} = 3'h0;
      8'h90: mode = 2'h2;
      default: ;
    endcase
    if (pend == 2'h0 && din == 8'h40) pend = 2'h1;
    else if (pend == 2'h0 && din == 8'h20) pend = 2'h2;
    else pend = 2'h0;
  end
  always @* begin
    drv = pd_n && !ce_n && !oe_n && we_n;
    if ((hv && addr[16:1] == 16'h0) || mode == 2'h2)
      rd_v = addr[0] ? DEV_ID : MFG_ID;
    else if (mode == 2'h1) rd_v = sr_lat;
    else rd_v = mem[addr[7:0]];
  end
  // a released bus must not keep looking valid
  always @* if (drv) last = rd_v;
  assign dout = drv ? rd_v : ~last;
endmodule

//--- tb_fci_host.sv
// self-checking bench for the flash command host
`timescale 1ns/1ps
module tb_fci_host;
  typedef struct packed {
    logic [3:0] op;
    logic [16:0] a;
    logic [7:0] wd;
    logic [7:0] rd;
    logic chk;
    logic [1:0] mode;
  } fci_row_t;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic ce_n, oe_n, we_n, dq_oe_n, pd_n, vpp, hv;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [16:0] f_addr;
  logic [7:0] dq_o, m_dout, dq_w;
  int failures, n_checks;
  // op, address, data, expected byte, check it, expected mode
  fci_row_t rows [18] = '{
    '{4'h0, 17'h12, 8'h00, 8'h48, 1'b1, 2'h0},
    '{4'h5, 17'h12, 8'h3C, 8'h00, 1'b0, 2'h1},
    '{4'h0, 17'h12, 8'h00, 8'h80, 1'b1, 2'h1},
    '{4'h1, 17'h00, 8'h00, 8'h00, 1'b0, 2'h0},
    '{4'h0, 17'h12, 8'h00, 8'h3C, 1'b1, 2'h0},
    '{4'h2, 17'h00, 8'h00, 8'h80, 1'b1, 2'h1},
    '{4'h3, 17'h00, 8'h00, 8'h00, 1'b0, 2'h2},
    '{4'h0, 17'h00, 8'h00, 8'hA7, 1'b1, 2'h2},
    '{4'h0, 17'h01, 8'h00, 8'h3C, 1'b1, 2'h2},
    '{4'hF, 17'h01, 8'h00, 8'h3C, 1'b1, 2'h2},
    '{4'h6, 17'h12, 8'h00, 8'h00, 1'b0, 2'h1},
    '{4'h7, 17'h00, 8'h00, 8'h00, 1'b0, 2'h1},
    '{4'h8, 17'h00, 8'h00, 8'h00, 1'b0, 2'h1},
    '{4'h4, 17'h00, 8'h00, 8'h00, 1'b0, 2'h1},
    '{4'h1, 17'h00, 8'h00, 8'h00, 1'b0, 2'h0},
    '{4'h0, 17'h34, 8'h00, 8'hFF, 1'b1, 2'h0},
    '{4'h9, 17'h00, 8'h00, 8'hA7, 1'b1, 2'h0},
    '{4'h9, 17'h01, 8'h00, 8'h3C, 1'b1, 2'h0}};
  assign dq_w = dq_oe_n ? m_dout : dq_o;
  fci_host dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_addr(f_addr), .chip_select_n(ce_n),
    .output_enable_n(oe_n), .write_strobe_n(we_n), .flash_dq_o(dq_o),
    .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_w), .powerdown_n(pd_n),
    .program_supply_high_level(vpp), .id_voltage_en(hv));
  fci_flash_model mdl_u (.addr(f_addr), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .pd_n(pd_n), .vpp(vpp), .hv(hv), .din(dq_w),
    .dout(m_dout));
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // leaves the final status word in d
  task automatic op_run(input logic [3:0] op, input logic [16:0] a,
                        input logic [7:0] wd, input logic v);
    int n;
    axi_wr(5'h04, 32'(a));
    axi_wr(5'h08, 32'(wd));
    axi_wr(5'h00, {22'h0, v, 5'h01, op});
    n = 0;
    do begin
      axi_rd(5'h10);
      n++;
    end while (d[0] !== 1'b0 && n < 200);
    chk(d[0], 1'b0, "op never finished");
  endtask
  task automatic print_verdict();
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // full run is under a thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    print_verdict();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (10) @(posedge aclk);
    chk({ce_n, oe_n, we_n, pd_n, dq_oe_n}, 5'h1F, "idle pins");
    aresetn <= 1'b1;
    axi_rd(5'h00);
    chk(d, 32'h0, "ctrl reset");
    axi_wr(5'h14, 32'h1);
    chk(r, 2'h2, "unmapped wr");
    axi_wr(5'h10, 32'h1);
    chk(r, 2'h2, "ro wr");
    axi_rd(5'h1C);
    chk(r, 2'h2, "unmapped rd");
    op_run(4'h6, 17'h12, 8'h00, 1'b0);
    chk(d[1], 1'b1, "erase no supply");
    axi_wr(5'h00, 32'h10);
    axi_wr(5'h00, 32'h10);
    axi_rd(5'h10);
    chk(d[1:0], 2'h1, "go while busy");
    repeat (40) @(posedge aclk);
    foreach (rows[i]) begin
      op_run(rows[i].op, rows[i].a, rows[i].wd, 1'b1);
      chk(d[5:4], rows[i].mode, "mode");
      axi_rd(5'h0C);
      if (rows[i].chk) chk(d[7:0], rows[i].rd, "byte");
    end
    op_run(4'h6, 17'h12, 8'h00, 1'b1);
    axi_wr(5'h00, 32'h100);
    repeat (3) @(posedge aclk);
    chk({pd_n, ce_n}, 2'h1, "powerdown");
    axi_wr(5'h00, 32'h0);
    repeat (60) @(posedge aclk);
    op_run(4'h0, 17'h12, 8'h00, 1'b1);
    chk(d[5:4], 2'h0, "wake mode");
    axi_rd(5'h0C);
    chk(d[7:0], 8'hFF, "wake byte");
    print_verdict();
  end
endmodule
